/* File: design/nand_host.sv */
`timescale 1ns/10ps
`include "nand_host_cfg.svh"

// Functional notes
// - Host holds chip enable low for every bus operation.
// - Command, address and data are taken at write enable rising edge.
// - Address latch enable high marks address cycles only.
// - Command latch enable high marks command cycles only.
// - Each read enable low pulse returns the next word on the bus.
// - Ready/busy is open drain; an external pull-up supplies the high level.
// - One shared bidirectional bus, 8 or 16 bits wide per variant.
// - Array holds 8192 blocks of 64 pages each.
// - Page is 2048 main plus 64 spare bytes, 2112 total.
module nand_host #(
  parameter int IO_W = `NH_IO_W,
  parameter int FIFO_DEPTH = `NH_FIFO_DEPTH,
  parameter int WAIT_LIMIT = `NH_WAIT_LIMIT
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic req_valid,
  input wire nand_host_pkg::req_s req,
  output logic req_ready,
  output logic done,
  output logic timeout,
  output logic rd_valid,
  output logic [IO_W-1:0] rd_data,
  input wire logic rd_ready,
  input wire logic protect,
  output logic ce_n,
  output logic cle,
  output logic ale,
  output logic we_n,
  output logic re_n,
  output logic wp_n,
  output logic [IO_W-1:0] io_out,
  output logic io_oe,
  input wire logic [IO_W-1:0] io_in,
  input wire logic rb_n_in,
  output logic rb_ready,
  output logic [`NH_CNT_W-1:0] col
);
  import nand_host_pkg::*;

  ////////////////////////////////////////////////////////////////////////
  localparam int CW = `NH_CNT_W;
  localparam int TW = `NH_TMR_W;
  localparam int PAGE_WORDS = `NH_PAGE_BYTES * 8 / IO_W;
  localparam logic [CW-1:0] PW = CW'(PAGE_WORDS);
  localparam logic [CW-1:0] COL_N = CW'(`NH_COL_CYCLES);
  localparam logic [CW-1:0] ROW_N = CW'(`NH_ROW_CYCLES);
  localparam logic [TW-1:0] SETUP_T = TW'(`NH_CYC(`NH_SETUP_NS) - 1);
  localparam logic [TW-1:0] STROBE_T = TW'(`NH_CYC(`NH_STROBE_NS) - 1);
  localparam logic [TW-1:0] RLOW_T = TW'(`NH_CYC(`NH_STROBE_NS) + `NH_SYNC_CYC - 1);
  localparam logic [TW-1:0] WB_T = TW'(`NH_CYC(`NH_WB_NS) - 1);
  localparam logic [`NH_WAIT_W-1:0] WAIT_MAX = `NH_WAIT_W'(WAIT_LIMIT);

  localparam st_s ST_RESET = '{
    state: S_IDLE,
    pin: '{ce_n: 1'b1, we_n: 1'b1, re_n: 1'b1, default: '0},
    req_ready: 1'b1,
    default: '0
  };

  st_s s_r;
  st_s s_nxt;
  logic fifo_ready;

  function automatic logic [CW-1:0] clamp(input logic [CW-1:0] v, input logic [CW-1:0] lim);
    return (v > lim) ? lim : v;
  endfunction

  function automatic logic [`NH_IO_MAX-1:0] addr_byte(input logic [`NH_SHIFT_W-1:0] sh);
    return `NH_IO_MAX'(sh[`NH_ADDR_BYTE_W-1:0]);
  endfunction

  ////////////////////////////////////////////////////////////////////////
  always_comb begin
    s_nxt = s_r;
    s_nxt.push = 1'b0;
    s_nxt.done = 1'b0;
    // ready/busy has an external pull-up; only its level is sampled
    s_nxt.rb_m = rb_n_in;
    s_nxt.rb_s = s_r.rb_m;
    s_nxt.io_m = `NH_IO_MAX'(io_in);
    s_nxt.io_s = s_r.io_m;
    s_nxt.pin.wp_n = ~protect;
    if (s_r.tmr != '0) begin
      s_nxt.tmr = s_r.tmr - 1'b1;
    end
    unique case (s_r.state)
      S_IDLE: begin
        if (req_valid && s_r.req_ready) begin
          s_nxt.req_ready = 1'b0;
          s_nxt.timeout = 1'b0;
          s_nxt.last = req.last;
          s_nxt.pin.ce_n = 1'b0;
          s_nxt.tmr = SETUP_T;
          s_nxt.state = S_SETUP;
          s_nxt.left = CW'(1);
          s_nxt.shift = `NH_SHIFT_W'(req.data);
          unique case (req.op)
            OP_CMD: begin
              s_nxt.pin.cle = 1'b1;
            end
            OP_ADDR: begin
              s_nxt.pin.ale = 1'b1;
            end
            OP_COL: begin
              s_nxt.pin.ale = 1'b1;
              s_nxt.col = clamp(req.col, PW - 1'b1);
              s_nxt.shift = `NH_SHIFT_W'(s_nxt.col);
              s_nxt.left = COL_N;
            end
            OP_ROW: begin
              s_nxt.pin.ale = 1'b1;
              s_nxt.shift = `NH_SHIFT_W'({req.block, req.page});
              s_nxt.left = ROW_N;
            end
            OP_WR: begin
            end
            OP_RD: begin
              s_nxt.left = clamp(req.count, PW - s_r.col);
              s_nxt.tmr = '0;
              s_nxt.state = S_RGAP;
            end
            default: begin
              s_nxt.tmr = WB_T;
              s_nxt.wait_cnt = '0;
              s_nxt.state = S_WAIT;
            end
          endcase
          s_nxt.pin.io = s_nxt.pin.ale ? addr_byte(s_nxt.shift) : req.data;
          // bus is driven only while read enable stays high
          s_nxt.pin.oe = (s_nxt.state == S_SETUP);
        end
      end
      S_SETUP: begin
        if (s_r.tmr == '0) begin
          s_nxt.pin.we_n = 1'b0;
          s_nxt.tmr = STROBE_T;
          s_nxt.state = S_WLOW;
        end
      end
      S_WLOW: begin
        if (s_r.tmr == '0) begin
          // rising edge latches the value held on the bus
          s_nxt.pin.we_n = 1'b1;
          s_nxt.tmr = STROBE_T;
          s_nxt.state = S_WHIGH;
        end
      end
      S_WHIGH: begin
        if (s_r.tmr == '0) begin
          if (s_r.left > CW'(1)) begin
            s_nxt.left = s_r.left - 1'b1;
            s_nxt.shift = s_r.shift >> `NH_ADDR_BYTE_W;
            s_nxt.pin.io = addr_byte(s_nxt.shift);
            s_nxt.pin.we_n = 1'b0;
            s_nxt.tmr = STROBE_T;
            s_nxt.state = S_WLOW;
          end else begin
            s_nxt.pin.cle = 1'b0;
            s_nxt.pin.ale = 1'b0;
            s_nxt.pin.oe = 1'b0;
            s_nxt.state = S_END;
          end
        end
      end
      S_RGAP: begin
        if (s_r.left == '0) begin
          s_nxt.state = S_END;
        end else if (s_r.tmr == '0 && fifo_ready) begin
          s_nxt.pin.re_n = 1'b0;
          s_nxt.tmr = RLOW_T;
          s_nxt.state = S_RLOW;
        end
      end
      S_RLOW: begin
        if (s_r.tmr == '0) begin
          // synchronised bus lags the pin by the synchroniser depth
          s_nxt.push = 1'b1;
          s_nxt.push_data = s_r.io_s;
          s_nxt.pin.re_n = 1'b1;
          s_nxt.col = s_r.col + 1'b1;
          s_nxt.left = s_r.left - 1'b1;
          s_nxt.tmr = STROBE_T;
          s_nxt.state = S_RGAP;
        end
      end
      S_WAIT: begin
        s_nxt.wait_cnt = s_r.wait_cnt + 1'b1;
        if (s_r.tmr == '0 && s_r.rb_s) begin
          s_nxt.state = S_END;
        end else if (s_r.wait_cnt == WAIT_MAX) begin
          s_nxt.timeout = 1'b1;
          s_nxt.state = S_END;
        end else begin
          s_nxt.state = S_WAIT;
        end
      end
      S_END: begin
        // released chip enable lets the device go to standby when idle
        s_nxt.pin.ce_n = s_r.last;
        s_nxt.req_ready = 1'b1;
        s_nxt.done = 1'b1;
        s_nxt.state = S_IDLE;
      end
      default: begin
        s_nxt = ST_RESET;
      end
    endcase
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      s_r <= ST_RESET;
    end else begin
      s_r <= s_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  nand_fifo #(
    .W(IO_W),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .clk(clk),
    .nrst(nrst),
    .in_valid(s_r.push),
    .in_data(s_r.push_data[IO_W-1:0]),
    .in_ready(fifo_ready),
    .out_valid(rd_valid),
    .out_data(rd_data),
    .out_ready(rd_ready)
  );

  assign req_ready = s_r.req_ready;
  assign done = s_r.done;
  assign timeout = s_r.timeout;
  assign ce_n = s_r.pin.ce_n;
  assign cle = s_r.pin.cle;
  assign ale = s_r.pin.ale;
  assign we_n = s_r.pin.we_n;
  assign re_n = s_r.pin.re_n;
  assign wp_n = s_r.pin.wp_n;
  assign io_out = s_r.pin.io[IO_W-1:0];
  assign io_oe = s_r.pin.oe;
  assign rb_ready = s_r.rb_s;
  assign col = s_r.col;

  ////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!nrst);

  sequence s_we_pulse;
    !s_r.pin.we_n [*5] ##1 s_r.pin.we_n;
  endsequence

  sequence s_re_pulse;
    !s_r.pin.re_n [*7] ##1 s_r.pin.re_n;
  endsequence

  sequence s_leave_wait;
    (s_r.state == S_END) ##1 (s_r.req_ready && s_r.state == S_IDLE);
  endsequence

  a_we_strobe: assert property ($fell(s_r.pin.we_n) |-> s_we_pulse)
    else $error("write strobe width wrong");
  a_we_value_held: assert property ($rose(s_r.pin.we_n) |-> $stable(s_r.pin.io) && s_r.pin.oe)
    else $error("bus changed at write strobe edge");
  a_we_chip_on: assert property (!s_r.pin.we_n |-> !s_r.pin.ce_n && s_r.pin.re_n)
    else $error("write strobe without chip enable");
  a_cle_cmd_hold: assert property ($fell(s_r.pin.we_n) && s_r.pin.cle |-> s_r.pin.cle [*6])
    else $error("command latch dropped before edge");
  a_ale_only: assert property (s_r.pin.ale |-> !s_r.pin.cle)
    else $error("address and command latch together");
  a_re_strobe: assert property ($fell(s_r.pin.re_n) |-> s_re_pulse)
    else $error("read strobe width wrong");
  a_re_no_drive: assert property (!s_r.pin.re_n |-> !s_r.pin.oe && !s_r.pin.ce_n)
    else $error("host drives bus during read strobe");
  a_col_step: assert property ($rose(s_r.pin.re_n) |-> s_r.col == CW'($past(s_r.col) + 1'b1))
    else $error("column did not advance");
  a_col_in_page: assert property (s_r.col <= PW)
    else $error("column beyond page end");
  a_busy_hold: assert property (s_r.state == S_WAIT && !s_r.rb_s && !s_nxt.timeout |=> s_r.state == S_WAIT)
    else $error("left wait while busy");
  a_ready_exit: assert property (s_r.state == S_WAIT && s_r.tmr == '0 && s_r.rb_s |=> s_leave_wait)
    else $error("ready not followed by completion");
  a_ce_standby: assert property (s_r.pin.ce_n |-> s_r.pin.we_n && s_r.pin.re_n && !s_r.pin.oe)
    else $error("strobe or drive with chip deselected");
  a_fifo_room: assert property (s_r.push |-> fifo_ready)
    else $error("read word pushed into full buffer");
endmodule

/* File: design/nand_host_cfg.svh */
`ifndef NAND_HOST_CFG_SVH
`define NAND_HOST_CFG_SVH

`define NH_CLK_PERIOD_PS 4000
`define NH_IO_W 16
`define NH_IO_MAX 16
`define NH_BLOCKS 8192
`define NH_PAGES 64
`define NH_BLK_W 13
`define NH_PG_W 6
`define NH_PAGE_BYTES 2112
`define NH_CNT_W 12
`define NH_SHIFT_W 24
`define NH_ADDR_BYTE_W 8
`define NH_COL_CYCLES 2
`define NH_ROW_CYCLES 3
`define NH_TMR_W 8
`define NH_SETUP_NS 10
`define NH_STROBE_NS 20
`define NH_WB_NS 100
`define NH_SYNC_CYC 2
`define NH_CYC(ns) ((((ns) * 1000) + `NH_CLK_PERIOD_PS - 1) / `NH_CLK_PERIOD_PS)
`define NH_WAIT_W 20
`define NH_WAIT_LIMIT 1000000
`define NH_FIFO_DEPTH 8

`endif

/* File: design/nand_host_pkg.sv */
package nand_host_pkg;
`include "nand_host_cfg.svh"

  typedef enum logic [2:0] {
    OP_CMD = 3'h0,
    OP_ADDR = 3'h1,
    OP_COL = 3'h2,
    OP_ROW = 3'h3,
    OP_WR = 3'h4,
    OP_RD = 3'h5,
    OP_WAIT = 3'h6
  } op_e;

  typedef struct packed {
    op_e op;
    logic last;
    logic [`NH_IO_MAX-1:0] data;
    logic [`NH_CNT_W-1:0] col;
    logic [`NH_BLK_W-1:0] block;
    logic [`NH_PG_W-1:0] page;
    logic [`NH_CNT_W-1:0] count;
  } req_s;

  typedef enum logic [7:0] {
    S_IDLE = 8'h01,
    S_SETUP = 8'h02,
    S_WLOW = 8'h04,
    S_WHIGH = 8'h08,
    S_RGAP = 8'h10,
    S_RLOW = 8'h20,
    S_WAIT = 8'h40,
    S_END = 8'h80
  } state_e;

  typedef struct packed {
    logic ce_n;
    logic cle;
    logic ale;
    logic we_n;
    logic re_n;
    logic wp_n;
    logic [`NH_IO_MAX-1:0] io;
    logic oe;
  } pins_s;

  typedef struct packed {
    state_e state;
    logic [`NH_TMR_W-1:0] tmr;
    logic [`NH_WAIT_W-1:0] wait_cnt;
    pins_s pin;
    logic [`NH_SHIFT_W-1:0] shift;
    logic [`NH_CNT_W-1:0] left;
    logic [`NH_CNT_W-1:0] col;
    logic last;
    logic req_ready;
    logic done;
    logic timeout;
    logic push;
    logic [`NH_IO_MAX-1:0] push_data;
    logic rb_m;
    logic rb_s;
    logic [`NH_IO_MAX-1:0] io_m;
    logic [`NH_IO_MAX-1:0] io_s;
  } st_s;

endpackage

/* File: design/nand_fifo.sv */
`timescale 1ns/10ps
module nand_fifo #(
  parameter int W = 8,
  parameter int DEPTH = 8
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic in_valid,
  input wire logic [W-1:0] in_data,
  output logic in_ready,
  output logic out_valid,
  output logic [W-1:0] out_data,
  input wire logic out_ready
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam logic [AW:0] FULL = (AW + 1)'(DEPTH);
  localparam logic [AW-1:0] LAST = AW'(DEPTH - 1);

  logic [W-1:0] mem [DEPTH];
  logic [AW-1:0] wr_r;
  logic [AW-1:0] rd_r;
  logic [AW:0] cnt_r;
  logic out_valid_r;
  logic [W-1:0] out_data_r;
  logic wr_en;
  logic rd_en;

  function automatic logic [AW-1:0] wrap_inc(input logic [AW-1:0] p);
    return (p == LAST) ? '0 : p + 1'b1;
  endfunction

  assign in_ready = (cnt_r != FULL);
  assign wr_en = in_valid && in_ready;
  // output register refills whenever it is empty or being taken
  assign rd_en = (cnt_r != '0) && (!out_valid_r || out_ready);
  assign out_valid = out_valid_r;
  assign out_data = out_data_r;

  always_ff @(posedge clk) begin
    if (wr_en) begin
      mem[wr_r] <= in_data;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      wr_r <= '0;
      rd_r <= '0;
      cnt_r <= '0;
      out_valid_r <= 1'b0;
      out_data_r <= '0;
    end else begin
      if (wr_en) begin
        wr_r <= wrap_inc(wr_r);
      end
      if (rd_en) begin
        rd_r <= wrap_inc(rd_r);
        out_data_r <= mem[rd_r];
        out_valid_r <= 1'b1;
      end else if (out_ready) begin
        out_valid_r <= 1'b0;
      end
      cnt_r <= cnt_r + (AW + 1)'(wr_en) - (AW + 1)'(rd_en);
    end
  end
endmodule

/* File: test/nand_dev_model.sv */
`timescale 1ns/10ps
module nand_dev_model #(
  parameter int IO_W = 16,
  parameter int BUSY_NS = 400
) (
  input wire logic ce_n,
  input wire logic cle,
  input wire logic ale,
  input wire logic we_n,
  input wire logic re_n,
  input wire logic wp_n,
  input wire logic [IO_W-1:0] bus,
  input wire logic hold_busy,
  output logic [IO_W-1:0] dev_io,
  output logic dev_oe,
  output logic rb_low,
  output logic standby
);
  logic [IO_W-1:0] pbuf [64];
  logic [IO_W-1:0] mem [64];
  logic [IO_W-1:0] rd_q;
  logic [IO_W-1:0] last_v;
  logic [11:0] col_r;
  int acnt;

  initial begin
    foreach (mem[i]) mem[i] = '1;
    foreach (pbuf[i]) pbuf[i] = '0;
    rd_q = '0;
    last_v = '0;
    col_r = 12'h000;
    acnt = 0;
    dev_oe = 1'b0;
    rb_low = 1'b0;
  end

  // released bus shows the inverse of the last word, never a stale copy
  assign dev_io = dev_oe ? rd_q : ~last_v;
  assign standby = ce_n && !rb_low;

  // array operation; the ready line is only ever pulled low
  task automatic run(input int kind);
    rb_low = 1'b1;
    #(BUSY_NS);
    for (int t = 0; t < 5000 && hold_busy; t++) #4;
    if (kind == 0) foreach (pbuf[i]) pbuf[i] = mem[i];
    if (kind == 1) foreach (mem[i]) mem[i] = pbuf[i];
    if (kind == 2) foreach (mem[i]) mem[i] = '1;
    rb_low = 1'b0;
  endtask

  always @(posedge we_n) begin
    if (!ce_n && !rb_low) begin
      if (cle) begin
        acnt = 0;
        if (bus[7:0] == 8'h30) run(0);
        if (bus[7:0] == 8'h10 && wp_n) run(1);
        if (bus[7:0] == 8'hd0 && wp_n) run(2);
      end else if (ale) begin
        if (acnt == 0) col_r[7:0] = bus[7:0];
        if (acnt == 1) col_r[11:8] = bus[3:0];
        acnt++;
      end else begin
        pbuf[col_r[5:0]] = bus;
        col_r = col_r + 12'h001;
      end
    end
  end

  always @(negedge re_n) begin
    if (!ce_n && !rb_low) begin
      #8;
      rd_q = pbuf[col_r[5:0]];
      dev_oe = !ce_n && !re_n;
    end
  end

  always @(posedge re_n or posedge ce_n) begin
    if (dev_oe) last_v = rd_q;
    dev_oe = 1'b0;
    if (!ce_n && !rb_low) col_r = col_r + 12'h001;
  end
endmodule

/* File: test/test_nand_host.sv */
`timescale 1ns/10ps
module test_nand_host;
  import nand_host_pkg::*;
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic req_valid = 1'b0;
  req_s req = '0;
  logic rd_ready = 1'b0;
  logic protect = 1'b0;
  logic hold_busy = 1'b0;
  logic req_ready, done, timeout, rd_valid, ce_n, cle, ale, we_n, re_n, wp_n, io_oe;
  logic rb_ready, dev_oe, rb_low, standby;
  logic [15:0] rd_data, io_out, dev_io, bus;
  logic [11:0] col;
  logic [15:0] exp_mem [64];
  logic saw_busy = 1'b0;
  logic [23:0] row_sh = '0;
  int error_cnt = 0;
  int checked = 0;
  int dones = 0;
  int dmark = 0;

  always #2 clk = ~clk;
  assign bus = io_oe ? io_out : dev_io;

  nand_host #(.IO_W(16), .FIFO_DEPTH(8), .WAIT_LIMIT(200)) uut (
    .clk(clk), .nrst(nrst), .req_valid(req_valid), .req(req), .req_ready(req_ready),
    .done(done), .timeout(timeout), .rd_valid(rd_valid), .rd_data(rd_data),
    .rd_ready(rd_ready), .protect(protect), .ce_n(ce_n), .cle(cle), .ale(ale),
    .we_n(we_n), .re_n(re_n), .wp_n(wp_n), .io_out(io_out), .io_oe(io_oe),
    .io_in(bus), .rb_n_in(!rb_low), .rb_ready(rb_ready), .col(col)
  );

  nand_dev_model #(.IO_W(16), .BUSY_NS(400)) dev (
    .ce_n(ce_n), .cle(cle), .ale(ale), .we_n(we_n), .re_n(re_n), .wp_n(wp_n),
    .bus(bus), .hold_busy(hold_busy), .dev_io(dev_io), .dev_oe(dev_oe),
    .rb_low(rb_low), .standby(standby)
  );

  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    checked++;
    if (got !== exp) begin
      error_cnt++;
      $display("mismatch %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic final_report();
    $display("checks %0d errors %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  task automatic hang(input string what);
    error_cnt++;
    $display("mismatch %s expected handshake seen none", what);
    final_report();
  endtask

  always @(posedge clk) begin
    if (done === 1'b1) dones++;
    if (rb_low) saw_busy = 1'b1;
    if (io_oe && (dev_oe || !re_n || ce_n)) chk("io drive", 32'h0, 32'h1);
  end

  always @(posedge we_n) begin
    if (cle && ale) chk("latch select", 32'h0, 32'h1);
    if (ale && !ce_n) row_sh = {bus[7:0], row_sh[23:8]};
    if (ale && bus[15:8] != 8'h00) chk("addr upper", 32'h0, 32'(bus[15:8]));
  end

  ////////////////////////////////////////////////////////////////////////////////
  task automatic send(input op_e op, input logic [15:0] d, input logic [11:0] c,
    input logic [11:0] n);
    int k;
    @(posedge clk);
    req.op <= op;
    req.last <= (op == OP_WAIT || op == OP_RD);
    req.data <= d;
    req.col <= c;
    req.count <= n;
    req_valid <= 1'b1;
    k = 0;
    do begin
      @(posedge clk);
      k++;
    end while (req_ready !== 1'b1 && k < 100);
    if (k >= 100) hang("req_ready");
    req_valid <= 1'b0;
    dmark = dones;
  endtask

  task automatic wait_done();
    int k;
    k = 0;
    do begin
      @(posedge clk);
      k++;
    end while (dones == dmark && done !== 1'b1 && k < 2000);
    if (k >= 2000) hang("done");
  endtask

  task automatic op1(input op_e op, input logic [15:0] d, input logic [11:0] c);
    send(op, d, c, 12'h000);
    wait_done();
  endtask

  task automatic prog(input logic [15:0] base, input int n);
    op1(OP_CMD, 16'h0080, 12'h000);
    op1(OP_COL, 16'h0000, 12'h000);
    op1(OP_ROW, 16'h0000, 12'h000);
    for (int i = 0; i < n; i++) begin
      op1(OP_WR, base + 16'(i), 12'h000);
      if (protect === 1'b0) exp_mem[i] = base + 16'(i);
    end
    saw_busy = 1'b0;
    op1(OP_CMD, 16'h0010, 12'h000);
    op1(OP_WAIT, 16'h0000, 12'h000);
  endtask

  task automatic erase();
    op1(OP_CMD, 16'h0060, 12'h000);
    op1(OP_ADDR, 16'h0043, 12'h000);
    op1(OP_ADDR, 16'h0001, 12'h000);
    op1(OP_ADDR, 16'h0000, 12'h000);
    chk("erase row", 32'({13'h0005, 6'h03}), 32'(row_sh));
    saw_busy = 1'b0;
    op1(OP_CMD, 16'h00d0, 12'h000);
    op1(OP_WAIT, 16'h0000, 12'h000);
    if (protect === 1'b0) foreach (exp_mem[i]) exp_mem[i] = '1;
  endtask

  task automatic load(input logic [11:0] c);
    op1(OP_CMD, 16'h0000, 12'h000);
    op1(OP_COL, 16'h0000, c);
    op1(OP_ROW, 16'h0000, 12'h000);
    chk("row addr", 32'({13'h0005, 6'h03}), 32'(row_sh));
    op1(OP_CMD, 16'h0030, 12'h000);
    op1(OP_WAIT, 16'h0000, 12'h000);
  endtask

  task automatic rd_back(input logic [11:0] c, input int n, input bit stall);
    int k;
    load(c);
    send(OP_RD, 16'h0000, c, 12'(n));
    if (stall) begin
      repeat (200) @(posedge clk);
      chk("col stalled", 32'(c) + 32'd9, 32'(col));
      chk("re_n stalled", 32'h1, 32'(re_n));
    end
    rd_ready <= 1'b1;
    for (int i = 0; i < n; i++) begin
      k = 0;
      do begin
        @(posedge clk);
        k++;
      end while (rd_valid !== 1'b1 && k < 500);
      if (k >= 500) hang("rd_valid");
      chk("rd_data", 32'(exp_mem[c + 12'(i)]), 32'(rd_data));
    end
    rd_ready <= 1'b0;
    wait_done();
    chk("col end", 32'(c) + 32'(n), 32'(col));
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  task automatic s_reset();
    chk("ce_n", 32'h1, 32'(ce_n));
    chk("io_oe", 32'h0, 32'(io_oe));
    chk("wp_n", 32'h0, 32'(wp_n));
    chk("we_n re_n", 32'h3, 32'({we_n, re_n}));
    @(posedge clk);
    nrst <= 1'b1;
  endtask

  task automatic s_program();
    prog(16'ha500, 16);
    chk("busy seen", 32'h1, 32'(saw_busy));
    chk("rb_ready", 32'h1, 32'(rb_ready));
    chk("ce_n standby", 32'h3, 32'({ce_n, standby}));
  endtask

  task automatic s_protect();
    protect <= 1'b1;
    repeat (3) @(posedge clk);
    chk("wp_n low", 32'h0, 32'(wp_n));
    prog(16'h1200, 4);
    chk("program busy", 32'h0, 32'(saw_busy));
    erase();
    chk("erase busy", 32'h0, 32'(saw_busy));
    rd_back(12'h000, 4, 1'b0);
    protect <= 1'b0;
    repeat (3) @(posedge clk);
    chk("wp_n high", 32'h1, 32'(wp_n));
  endtask

  task automatic s_erase();
    erase();
    chk("erase busy", 32'h1, 32'(saw_busy));
    rd_back(12'h00a, 3, 1'b0);
  endtask

  task automatic s_timeout();
    @(posedge clk);
    hold_busy <= 1'b1;
    load(12'h000);
    chk("timeout set", 32'h1, 32'(timeout));
    chk("rb busy", 32'h0, 32'(rb_ready));
    hold_busy <= 1'b0;
    op1(OP_WAIT, 16'h0000, 12'h000);
    chk("timeout clear", 32'h0, 32'(timeout));
    chk("rb ready", 32'h1, 32'(rb_ready));
    op1(OP_COL, 16'h0000, 12'hfff);
    chk("col clamp", 32'h41f, 32'(col));
    rd_ready <= 1'b1;
    send(OP_RD, 16'h0000, 12'h000, 12'h005);
    wait_done();
    rd_ready <= 1'b0;
    chk("col page end", 32'h420, 32'(col));
  endtask

  initial begin
    foreach (exp_mem[i]) exp_mem[i] = '1;
    req.block = 13'h0005;
    req.page = 6'h03;
    repeat (9) @(posedge clk);
    s_reset();
    s_program();
    rd_back(12'h002, 5, 1'b0);
    rd_back(12'h000, 12, 1'b1);
    s_protect();
    s_erase();
    s_timeout();
    final_report();
  end
endmodule
